// ==== testbench/mbst_scan_ctl.sv ====
`default_nettype none
module mbst_scan_ctl (
    input  wire logic clock,
    input  wire logic tdo,
    input  wire logic tdo_oe,
    output var  logic tck,
    output var  logic tms,
    output var  logic tdi
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last = 1'h0;
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h1;
    end
    // One test clock of 200 ns; mode and data move only while tck is low
    task automatic tick(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clock);
        tck = 1'h1;
        repeat (4) @(negedge clock);
        q = tdo_oe ? tdo : ~last;
        last = q;
        tck = 1'h0;
    endtask
endmodule
`default_nettype wire

// ==== testbench/mbst_tap_properties.sv ====
`default_nettype none
module mbst_tap_properties #(
    parameter BSR_LEN = 107
) (
    input wire logic               clock,
    input wire logic               rst_n,
    input wire logic               tck,
    input wire logic               tms,
    input wire logic               tdo,
    input wire logic               tdo_oe,
    input wire logic               tms_pull_en,
    input wire logic               tdi_pull_en,
    input wire logic               mem_out_hiz,
    input wire logic               extest_drive,
    input wire logic [BSR_LEN-1:0] bsr_drive_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       tck_q;
    logic       last_tms;
    logic [2:0] hi_cnt;
    // Sees tck two clocks sooner than the design, so waits below leave margin
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tck_q    <= 1'h0;
            last_tms <= 1'h1;
            hi_cnt   <= 3'h0;
        end else begin
            tck_q <= tck;
            if (tck && !tck_q) begin
                last_tms <= tms;
                hi_cnt   <= !tms ? 3'h0 : (hi_cnt == 3'h5 ? 3'h5 : hi_cnt + 3'h1);
            end
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    pull_up_a: assert property (tms_pull_en && tdi_pull_en)
        else $error("pull enable dropped");
    tdo_edge_a: assert property ($changed({tdo, tdo_oe}) |-> !$past(tck, 2))
        else $error("tdo moved outside tck low");
    ctrl_edge_a: assert property (
        $changed({mem_out_hiz, extest_drive, bsr_drive_data}) |-> $past(tck, 2))
        else $error("control output moved outside tck high");
    frozen_tck_a: assert property (
        !tck [*8] |-> $stable({tdo_oe, mem_out_hiz, bsr_drive_data}))
        else $error("outputs moved with tck idle");
    mode_reset_a: assert property (
        hi_cnt == 3'h5 |-> ##6 !(tdo_oe || mem_out_hiz || extest_drive))
        else $error("five high mode bits did not reset");
    shift_entry_a: assert property ($rose(tdo_oe) |-> !last_tms)
        else $error("tdo enabled without shift entry");
    shift_exit_a: assert property ($fell(tdo_oe) |-> last_tms)
        else $error("tdo released without shift exit");
    float_excl_a: assert property (!(mem_out_hiz && extest_drive))
        else $error("float and external drive together");
endmodule
bind mbst_tap mbst_tap_properties #(.BSR_LEN(BSR_LEN)) chk (
    .clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe),
    .tms_pull_en(tms_pull_en), .tdi_pull_en(tdi_pull_en), .mem_out_hiz(mem_out_hiz),
    .extest_drive(extest_drive), .bsr_drive_data(bsr_drive_data));
`default_nettype wire

// ==== testbench/testbench.sv ====
`default_nettype none
`include "mbst_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [2:0] ir; logic hiz; logic ext; int len;} mbst_row_t;
    mbst_row_t rows [8] = '{'{3'h0, 1'h0, 1'h1, 107}, '{3'h1, 1'h0, 1'h0, 32},
        '{3'h2, 1'h1, 1'h0, 107}, '{3'h3, 1'h0, 1'h0, 1}, '{3'h4, 1'h0, 1'h0, 107},
        '{3'h5, 1'h0, 1'h0, 1}, '{3'h6, 1'h0, 1'h0, 1}, '{3'h7, 1'h0, 1'h0, 1}};
    localparam logic [4:0] CAPSEQ = 5'h0d;
    logic         clock = 1'h0;
    logic         rst_n = 1'h0;
    logic [106:0] pad_snap_data = 107'h0;
    logic         pad_snap_valid = 1'h0;
    wire          tck, tms, tdi;
    logic         tdo, tdo_oe, tms_pull_en, tdi_pull_en, pad_snap_ready;
    logic         mem_out_hiz, extest_drive, q;
    logic [106:0] bsr_drive_data;
    logic [139:0] got;
    int           miscompares = 0, checks_done = 0, cycles = 0, acc = 0, nb = 0, rdy;
    always #12.5 clock = ~clock;
    mbst_scan_ctl ctl (.clock(clock), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
        .tdi(tdi));
    mbst_tap dut (.clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .tms_pull_en(tms_pull_en), .tdi_pull_en(tdi_pull_en),
        .pad_snap_data(pad_snap_data), .pad_snap_valid(pad_snap_valid),
        .pad_snap_ready(pad_snap_ready), .mem_out_hiz(mem_out_hiz),
        .extest_drive(extest_drive), .bsr_drive_data(bsr_drive_data));
    // ----
    // Helpers
    // ----
    function automatic logic [106:0] snap(input int k);
        return {107{1'h1}} / (k + 3);
    endfunction
    task automatic check(input string name, input logic [127:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task complete_run;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic t(input logic m, input logic d);
        ctl.tick(m, d, q);
    endtask
    task automatic upd_idle;
        t(1'h1, 1'h0);
        t(1'h0, 1'h0);
    endtask
    task automatic enter_dr;
        for (int k = 0; k < 3; k++) t(k == 0, 1'h0);
    endtask
    task automatic load_ir(input logic [2:0] ir);
        logic [2:0] cap;
        for (int k = 0; k < 4; k++) t(k < 2, 1'h0);
        for (int k = 0; k < 3; k++) begin
            t(k == 2, ir[k]);
            cap[k] = q;
        end
        check("ir capture", cap, 3'h1);
        upd_idle();
    endtask
    // Shifts len+1 bits: a marker one comes out last, a one lands in bit 0
    task automatic shift_dr(input int len);
        enter_dr();
        for (int k = 0; k <= len; k++) begin
            t(k == len, k < 2);
            got[k] = q;
        end
        upd_idle();
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    // ----
    // Sequence
    // ----
    initial begin
        repeat (5) @(posedge clock);
        @(negedge clock);
        rst_n = 1'h1;
        check("oe reset", tdo_oe, 1'h0);
        check("pulls", {tms_pull_en, tdi_pull_en}, 2'h3);
        check("modes reset", {mem_out_hiz, extest_drive}, 2'h0);
        check("drive reset", bsr_drive_data, 107'h0);
        pad_snap_valid = 1'h1;
        repeat (20) begin
            pad_snap_data = snap(acc);
            rdy = pad_snap_ready;
            @(negedge clock);
            acc += rdy;
        end
        pad_snap_valid = 1'h0;
        check("words taken", acc, 32'h10);
        check("full", pad_snap_ready, 1'h0);
        for (int k = 0; k < 6; k++) t(k < 5, 1'h0);
        foreach (rows[i]) begin
            load_ir(rows[i].ir);
            check("modes", {mem_out_hiz, extest_drive, tdo_oe},
                {rows[i].hiz, rows[i].ext, 1'h0});
            shift_dr(rows[i].len);
            check("length", got[rows[i].len], 1'h1);
            if (rows[i].len == 32) check("id", got[31:0], `MBST_ID_DEFAULT);
            if (rows[i].len == 1) check("bypass", got[0], 1'h0);
            if (rows[i].len == 107) begin
                check("capture", got[106:0], snap(nb));
                check("update", bsr_drive_data, 107'h1);
                check("refill", pad_snap_ready, 1'h1);
                nb++;
            end
        end
        load_ir(3'h2);
        enter_dr();
        nb++;
        repeat (4) t(1'h1, 1'h0);
        check("four high", mem_out_hiz, 1'h1);
        upd_idle();
        check("five high", mem_out_hiz, 1'h0);
        shift_dr(32);
        check("id again", got[31:0], `MBST_ID_DEFAULT);
        load_ir(3'h4);
        repeat (16 - nb) for (int k = 0; k < 5; k++) t(CAPSEQ[k], 1'h0);
        shift_dr(107);
        check("empty keeps", got[106:0], snap(15));
        load_ir(3'h2);
        rst_n = 1'h0;
        @(negedge clock);
        check("power up", {mem_out_hiz, tdo_oe}, 2'h0);
        check("drive power up", bsr_drive_data, 107'h0);
        rst_n = 1'h1;
        repeat (2) @(negedge clock);
        check("after release", {mem_out_hiz, extest_drive, tdo_oe}, 3'h0);
        t(1'h0, 1'h0);
        shift_dr(32);
        check("id power up", got[31:0], `MBST_ID_DEFAULT);
        complete_run();
    end
endmodule
`default_nettype wire

// ==== verilog/mbst_defines.vh ====
`ifndef MBST_DEFINES_VH
`define MBST_DEFINES_VH

// ----------------------------------------
// Register lengths
// ----------------------------------------
`define MBST_IR_LEN        3
`define MBST_ID_LEN        32
`define MBST_BSR_LEN       107
`define MBST_FIFO_DEPTH    16

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define MBST_INS_EXTEST    3'h0
`define MBST_INS_IDCODE    3'h1
`define MBST_INS_SAMPLEZ   3'h2
`define MBST_INS_SAMPLE    3'h4
`define MBST_INS_BYPASS    3'h7
`define MBST_IR_CAPTURE    3'h1

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define MBST_ID_DEFAULT    32'h0a5c_3001
`define MBST_TCK_MIN_NS    50

`endif

// ==== verilog/mbst_fifo.v ====
`default_nettype none

module mbst_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clock,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output reg              in_ready,
    output wire [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready
);

    // ----------------------------------------
    // Storage and pointers
    // ----------------------------------------
    // DEPTH must equal 2**AW so the pointers wrap by themselves
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    reg [AW:0]      next_count;
    wire            push;
    wire            pop;

    assign push     = in_valid & in_ready;
    assign pop      = out_ready & out_valid;
    assign out_data = mem[rd_ptr];

    always @* begin
        next_count = count;
        if (push & ~pop) begin
            next_count = count + {{AW{1'h0}}, 1'h1};
        end else if (pop & ~push) begin
            next_count = count - {{AW{1'h0}}, 1'h1};
        end
    end

    always @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Flags are registered so both ready and valid leave straight from flops
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr    <= {AW{1'h0}};
            rd_ptr    <= {AW{1'h0}};
            count     <= {(AW+1){1'h0}};
            in_ready  <= 1'h1;
            out_valid <= 1'h0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + {{(AW-1){1'h0}}, 1'h1};
            end
            if (pop) begin
                rd_ptr <= rd_ptr + {{(AW-1){1'h0}}, 1'h1};
            end
            count     <= next_count;
            in_ready  <= (next_count != DEPTH[AW:0]);
            out_valid <= (next_count != {(AW+1){1'h0}});
        end
    end

endmodule

`default_nettype wire

// ==== verilog/mbst_tap.v ====
// Function
// - Only a reduced set of boundary-scan instructions is implemented.
// - Test data and mode select inputs are weakly pulled high.
// - All test inputs are sampled on rising test clock edges.
// - Serial output changes only on falling test clock edges.
// - Controller advances only by mode select sampled on each rising edge.
// - Shift path chosen by controller state and current instruction.
// - Five rising edges with mode select high reach test-logic-reset.
// - Power-up reset forces the controller into test-logic-reset.
// - Identification instruction is default; selects a 32-bit ID register.
// - Bypass places a single-bit register in the serial path.
// - Sample-with-float floats memory outputs, captures and shifts pad states.
`include "mbst_defines.vh"
`default_nettype none

module mbst_tap #(
    parameter        BSR_LEN    = `MBST_BSR_LEN,
    parameter        FIFO_DEPTH = `MBST_FIFO_DEPTH,
    parameter        FIFO_AW    = 4,
    // Identification value is arbitrary
    parameter [31:0] ID_CODE    = `MBST_ID_DEFAULT
) (
    input  wire               clock,
    input  wire               rst_n,
    input  wire               tck,
    input  wire               tms,
    input  wire               tdi,
    output reg                tdo,
    output reg                tdo_oe,
    output reg                tms_pull_en,
    output reg                tdi_pull_en,
    input  wire [BSR_LEN-1:0] pad_snap_data,
    input  wire               pad_snap_valid,
    output wire               pad_snap_ready,
    output reg                mem_out_hiz,
    output reg                extest_drive,
    output reg  [BSR_LEN-1:0] bsr_drive_data
);

    // ----------------------------------------
    // Controller states
    // ----------------------------------------
    localparam [3:0] ST_RESET   = 4'h0;
    localparam [3:0] ST_IDLE    = 4'h1;
    localparam [3:0] ST_SEL_DR  = 4'h2;
    localparam [3:0] ST_CAP_DR  = 4'h3;
    localparam [3:0] ST_SH_DR   = 4'h4;
    localparam [3:0] ST_EX1_DR  = 4'h5;
    localparam [3:0] ST_PA_DR   = 4'h6;
    localparam [3:0] ST_EX2_DR  = 4'h7;
    localparam [3:0] ST_UP_DR   = 4'h8;
    localparam [3:0] ST_SEL_IR  = 4'h9;
    localparam [3:0] ST_CAP_IR  = 4'ha;
    localparam [3:0] ST_SH_IR   = 4'hb;
    localparam [3:0] ST_EX1_IR  = 4'hc;
    localparam [3:0] ST_PA_IR   = 4'hd;
    localparam [3:0] ST_EX2_IR  = 4'he;
    localparam [3:0] ST_UP_IR   = 4'hf;

    localparam IR_LEN = `MBST_IR_LEN;
    localparam ID_LEN = `MBST_ID_LEN;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Test pins are asynchronous to clock; the third tck stage is for edge finding
    reg tck_s1;
    reg tck_s2;
    reg tck_s3;
    reg tms_s1;
    reg tms_s2;
    reg tdi_s1;
    reg tdi_s2;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tck_s1 <= 1'h0;
            tck_s2 <= 1'h0;
            tck_s3 <= 1'h0;
            tms_s1 <= 1'h1;
            tms_s2 <= 1'h1;
            tdi_s1 <= 1'h1;
            tdi_s2 <= 1'h1;
        end else begin
            tck_s1 <= tck;
            tck_s2 <= tck_s1;
            tck_s3 <= tck_s2;
            tms_s1 <= tms;
            tms_s2 <= tms_s1;
            tdi_s1 <= tdi;
            tdi_s2 <= tdi_s1;
        end
    end

    wire tck_rise;
    wire tck_fall;

    // A test clock held low yields no edges, so all scan logic below stays still; the pad snapshot queue still fills
    assign tck_rise = tck_s2 & ~tck_s3;
    assign tck_fall = ~tck_s2 & tck_s3;

    // ----------------------------------------
    // Controller state machine
    // ----------------------------------------
    reg [3:0] state;
    reg [3:0] next_state;

    always @* begin
        case (state)
            ST_RESET:  next_state = tms_s2 ? ST_RESET  : ST_IDLE;
            ST_IDLE:   next_state = tms_s2 ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tms_s2 ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms_s2 ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  next_state = tms_s2 ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = tms_s2 ? ST_UP_DR  : ST_PA_DR;
            ST_PA_DR:  next_state = tms_s2 ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: next_state = tms_s2 ? ST_UP_DR  : ST_SH_DR;
            ST_UP_DR:  next_state = tms_s2 ? ST_SEL_DR : ST_IDLE;
            // Five high samples from any state end here
            ST_SEL_IR: next_state = tms_s2 ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: next_state = tms_s2 ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  next_state = tms_s2 ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = tms_s2 ? ST_UP_IR  : ST_PA_IR;
            ST_PA_IR:  next_state = tms_s2 ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: next_state = tms_s2 ? ST_UP_IR  : ST_SH_IR;
            ST_UP_IR:  next_state = tms_s2 ? ST_SEL_DR : ST_IDLE;
            default:   next_state = ST_RESET;
        endcase
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_RESET;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // State decode
    // ----------------------------------------
    // Capture, shift and update below fire on the tck rise that leaves the decoded state; tdo follows on the fall
    wire in_cap_dr;
    wire in_sh_dr;
    wire in_up_dr;
    wire in_cap_ir;
    wire in_sh_ir;
    wire in_up_ir;
    wire in_shift;

    assign in_cap_dr = (state == ST_CAP_DR);
    assign in_sh_dr  = (state == ST_SH_DR);
    assign in_up_dr  = (state == ST_UP_DR);
    assign in_cap_ir = (state == ST_CAP_IR);
    assign in_sh_ir  = (state == ST_SH_IR);
    assign in_up_ir  = (state == ST_UP_IR);
    assign in_shift  = in_sh_dr | in_sh_ir;

    // ----------------------------------------
    // Instruction decode
    // ----------------------------------------
    reg  [IR_LEN-1:0] ir;
    reg  [IR_LEN-1:0] ir_sr;
    wire              sel_id;
    wire              sel_bsr;

    // Reserved codes fall back to bypass
    assign sel_id  = (ir == `MBST_INS_IDCODE);
    assign sel_bsr = (ir == `MBST_INS_EXTEST) | (ir == `MBST_INS_SAMPLE) |
                     (ir == `MBST_INS_SAMPLEZ);

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ir    <= `MBST_INS_IDCODE;
            ir_sr <= `MBST_IR_CAPTURE;
        end else if (tck_rise) begin
            if (next_state == ST_RESET) begin
                ir <= `MBST_INS_IDCODE;
            end else if (in_up_ir) begin
                ir <= ir_sr;
            end
            if (in_cap_ir) begin
                ir_sr <= `MBST_IR_CAPTURE;
            end else if (in_sh_ir) begin
                ir_sr <= {tdi_s2, ir_sr[IR_LEN-1:1]};
            end
        end
    end

    // ----------------------------------------
    // Data registers
    // ----------------------------------------
    reg  [ID_LEN-1:0]  id_sr;
    reg                byp_sr;
    reg  [BSR_LEN-1:0] bsr_sr;
    wire [BSR_LEN-1:0] snap_data;
    wire               snap_valid;
    wire               snap_pop;

    // Capture takes the oldest pad snapshot; with none queued the cells keep their value
    assign snap_pop = tck_rise & in_cap_dr & sel_bsr & snap_valid;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            id_sr  <= {ID_LEN{1'h0}};
            byp_sr <= 1'h0;
            bsr_sr <= {BSR_LEN{1'h0}};
        end else if (tck_rise) begin
            if (in_cap_dr) begin
                byp_sr <= 1'h0;
                if (sel_id) begin
                    id_sr <= ID_CODE;
                end
                if (snap_pop) begin
                    bsr_sr <= snap_data;
                end
            end else if (in_sh_dr) begin
                if (sel_id) begin
                    id_sr <= {tdi_s2, id_sr[ID_LEN-1:1]};
                end else if (sel_bsr) begin
                    bsr_sr <= {tdi_s2, bsr_sr[BSR_LEN-1:1]};
                end else begin
                    byp_sr <= tdi_s2;
                end
            end
        end
    end

    // ----------------------------------------
    // Pad control
    // ----------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_out_hiz    <= 1'h0;
            extest_drive   <= 1'h0;
            bsr_drive_data <= {BSR_LEN{1'h0}};
            tms_pull_en    <= 1'h1;
            tdi_pull_en    <= 1'h1;
        end else begin
            mem_out_hiz  <= (ir == `MBST_INS_SAMPLEZ);
            extest_drive <= (ir == `MBST_INS_EXTEST);
            tms_pull_en  <= 1'h1;
            tdi_pull_en  <= 1'h1;
            if (tck_rise && in_up_dr && sel_bsr) begin
                bsr_drive_data <= bsr_sr;
            end
        end
    end

    // ----------------------------------------
    // Serial output
    // ----------------------------------------
    reg shift_bit;

    always @* begin
        if (in_sh_ir) begin
            shift_bit = ir_sr[0];
        end else if (sel_id) begin
            shift_bit = id_sr[0];
        end else if (sel_bsr) begin
            shift_bit = bsr_sr[0];
        end else begin
            shift_bit = byp_sr;
        end
    end

    // Output is launched half a cycle ahead of the next sampling edge
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tdo    <= 1'h0;
            tdo_oe <= 1'h0;
        end else if (tck_fall) begin
            tdo    <= shift_bit;
            tdo_oe <= in_shift;
        end
    end

    // ----------------------------------------
    // Pad snapshot queue
    // ----------------------------------------
    // Pad logic on this clock hands in snapshots; the queue decouples them from scan pace
    mbst_fifo #(
        .WIDTH (BSR_LEN),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_snap_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_data   (pad_snap_data),
        .in_valid  (pad_snap_valid),
        .in_ready  (pad_snap_ready),
        .out_data  (snap_data),
        .out_valid (snap_valid),
        .out_ready (snap_pop)
    );

endmodule

`default_nettype wire
